// >>> tb/ifeb_core_model.sv
`timescale 1ns/1ns
// core side: gates flag sources, feeds outside flags, samples requests
module ifeb_core_model
    import ifeb_pkg::*;
(
    // clock
    input  wire logic         aclk,
    // settings chosen by the bench
    input  wire ifeb_flag_t   gate_cfg,
    input  wire ifeb_enable_t ext_cfg,
    // request lines from the block
    input  wire ifeb_flag_t   flag_request,
    // levels toward the block
    output ifeb_flag_t        flag_src_enable,
    output ifeb_enable_t      enable_src_flag,
    // requests seen at the last edge
    output ifeb_flag_t        seen
);
    // levels move only just after an edge, as real logic would
    always_ff @(posedge aclk) begin
        flag_src_enable <= gate_cfg;
        enable_src_flag <= ext_cfg;
        seen            <= flag_request;
    end
endmodule : ifeb_core_model

// >>> tb/ifeb_top_test.sv
`timescale 1ns/1ns
// self-checking bench for the flag and enable bank
module ifeb_top_test
    import ifeb_pkg::*;
;
    // clock, reset and bus master side
    logic                  aclk          = 1'b0;
    logic                  aresetn       = 1'b0;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr  = '0;
    logic [AXI_ADDR_W-1:0] s_axi_araddr  = '0;
    logic [AXI_DATA_W-1:0] s_axi_wdata   = '0;
    logic [AXI_STRB_W-1:0] s_axi_wstrb   = '0;
    logic                  s_axi_awvalid = 1'b0;
    logic                  s_axi_wvalid  = 1'b0;
    logic                  s_axi_arvalid = 1'b0;
    // responses are always accepted at once
    logic                  s_axi_bready  = 1'b1;
    logic                  s_axi_rready  = 1'b1;
    logic                  s_axi_awready, s_axi_wready, s_axi_arready;
    logic                  s_axi_bvalid, s_axi_rvalid, irq;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic [AXI_DATA_W-1:0] s_axi_rdata;
    // event side and core model
    ifeb_flag_t            flag_event    = '0;
    ifeb_flag_t            gate_cfg      = 16'hffff;
    ifeb_enable_t          ext_cfg       = 16'hffff;
    ifeb_flag_t            flag_request, flag_src_enable, seen;
    ifeb_enable_t          enable_request, enable_src_flag;
    // scoreboard
    int                    miscompares   = 0;
    int                    samples_checked = 0;

    always #5 aclk = ~aclk;

    ifeb_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .flag_event(flag_event),
        .flag_src_enable(flag_src_enable),
        .enable_src_flag(enable_src_flag), .flag_request(flag_request),
        .enable_request(enable_request), .irq(irq));

    ifeb_core_model core (.aclk(aclk), .gate_cfg(gate_cfg),
        .ext_cfg(ext_cfg), .flag_request(flag_request),
        .flag_src_enable(flag_src_enable),
        .enable_src_flag(enable_src_flag), .seen(seen));

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // one value comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask : chk

    // bus write: both halves offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        // no cycle count is assumed; only the watchdog ends a lost wait
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
    endtask : wr

    // bus read and compare of data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er, input string what);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, exp, what);
        chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
    endtask : rd

    // one-cycle event pulse
    task automatic pulse(input ifeb_flag_t e);
        flag_event <= e;
        @(posedge aclk);
        flag_event <= '0;
        @(posedge aclk);
    endtask : pulse

    task automatic t_reset;
        rd(OFS_FLAG, 32'h0, RESP_OKAY, "flag after reset");
        rd(OFS_ENABLE, 32'h0, RESP_OKAY, "enable after reset");
        chk(32'(irq), 32'h0, "irq after reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_rw;
        wr(OFS_FLAG, 32'hffffffff, 4'hf, RESP_OKAY);
        rd(OFS_FLAG, 32'h0000ffdf, RESP_OKAY, "flag bit 5");
        wr(OFS_ENABLE, 32'hffffffff, 4'hf, RESP_OKAY);
        rd(OFS_ENABLE, 32'h00007fff, RESP_OKAY, "enable bit 15");
        // only the low byte lane is written
        wr(OFS_ENABLE, 32'h0, 4'h1, RESP_OKAY);
        rd(OFS_ENABLE, 32'h00007f00, RESP_OKAY, "byte lane");
        wr(OFS_ENABLE, 32'h0, 4'hf, RESP_OKAY);
        wr(OFS_FLAG, 32'h0, 4'hf, RESP_OKAY);
        rd(OFS_FLAG, 32'h0, RESP_OKAY, "flag cleared");
        $display("test read write done");
    endtask : t_rw

    // every source: event sets its own bit only, request follows
    task automatic t_flags;
        logic [15:0] exp;
        for (int i = 0; i < 16; i++) begin
            pulse(ifeb_flag_t'(16'h1 << i));
            exp = (i == 5) ? 16'h0 : 16'h1 << i;
            rd(OFS_FLAG, {16'h0, exp}, RESP_OKAY, "flag position");
            chk({16'h0, flag_request}, {16'h0, exp}, "flag req");
            wr(OFS_FLAG, 32'h0, 4'hf, RESP_OKAY);
        end
        $display("test flags done");
    endtask : t_flags

    // every enable position, then gating by outside flags
    task automatic t_enables;
        logic [15:0] exp;
        for (int i = 0; i < 16; i++) begin
            exp = (i == 15) ? 16'h0 : 16'h1 << i;
            wr(OFS_ENABLE, 32'h1 << i, 4'hf, RESP_OKAY);
            rd(OFS_ENABLE, {16'h0, exp}, RESP_OKAY, "enable bit");
            chk({16'h0, enable_request}, {16'h0, exp}, "en req");
        end
        ext_cfg <= 16'h0f0f;
        wr(OFS_ENABLE, 32'h5555, 4'hf, RESP_OKAY);
        chk({16'h0, enable_request}, 32'h0505, "gated enable");
        wr(OFS_ENABLE, 32'h0, 4'hf, RESP_OKAY);
        chk({16'h0, enable_request}, 32'h0, "enable off");
        $display("test enables done");
    endtask : t_enables

    // request only with gate open; event beats a clearing write
    task automatic t_gate;
        gate_cfg <= '0;
        pulse(16'h8000);
        chk({16'h0, flag_request}, 32'h0, "blocked request");
        gate_cfg <= 16'h8000;
        // gate flop, then the model's sample flop
        repeat (3) @(posedge aclk);
        chk({16'h0, seen}, 32'h8000, "open request");
        fork
            wr(OFS_FLAG, 32'h0, 4'hf, RESP_OKAY);
            begin
                // event only at the commit edge of the clearing write
                @(posedge aclk);
                flag_event <= 16'h8000;
                @(posedge aclk);
                flag_event <= '0;
            end
        join
        chk({16'h0, flag_request}, 32'h8000, "set wins");
        wr(OFS_FLAG, 32'h0, 4'hf, RESP_OKAY);
        chk({16'h0, flag_request}, 32'h0, "cleared request");
        $display("test gate done");
    endtask : t_gate

    // block events: overrun, decode error, mask and clear
    task automatic t_irq;
        rd(OFS_IRQ_STATUS, 32'h2, RESP_OKAY, "overrun status");
        chk(32'(irq), 32'h0, "irq masked");
        rd(8'h14, 32'h0, RESP_SLVERR, "unmapped read");
        rd(OFS_IRQ_STATUS, 32'h3, RESP_OKAY, "decode status");
        wr(OFS_IRQ_ENABLE, 32'h1, 4'hf, RESP_OKAY);
        chk(32'(irq), 32'h1, "irq raised");
        wr(OFS_IRQ_CLEAR, 32'h1, 4'hf, RESP_OKAY);
        chk(32'(irq), 32'h0, "irq cleared");
        wr(OFS_IRQ_ENABLE, 32'h3, 4'hf, RESP_OKAY);
        chk(32'(irq), 32'h1, "overrun irq");
        wr(OFS_IRQ_CLEAR, 32'h2, 4'hf, RESP_OKAY);
        rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY, "status empty");
        // write-only word: zero data with an error response
        rd(OFS_IRQ_CLEAR, 32'h0, RESP_SLVERR, "clear reads zero");
        wr(OFS_IRQ_ENABLE, 32'h0, 4'hf, RESP_OKAY);
        wr(OFS_IRQ_STATUS, 32'h3, 4'hf, RESP_SLVERR);
        $display("test irq done");
    endtask : t_irq

    // main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_rw;
        t_flags;
        t_enables;
        t_gate;
        t_irq;
        end_sim;
    end

    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        end_sim;
    end
endmodule : ifeb_top_test

// >>> verilog/ifeb_pkg.sv
package ifeb_pkg;

    // register bus widths
    localparam int unsigned AXI_ADDR_W = 8;
    localparam int unsigned AXI_DATA_W = 32;
    localparam int unsigned AXI_STRB_W = 4;
    localparam int unsigned REG_W      = 16;

    // byte offsets of the word-aligned registers
    localparam logic [AXI_ADDR_W-1:0] OFS_FLAG       = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] OFS_ENABLE     = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h0c;
    localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h10;

    // implemented-bit masks: flag bit 5 and enable bit 15 are absent
    localparam logic [REG_W-1:0] FLAG_IMPL_MASK   = 16'hffdf;
    localparam logic [REG_W-1:0] ENABLE_IMPL_MASK = 16'h7fff;

    // reset values
    localparam logic [REG_W-1:0] FLAG_RESET   = 16'h0000;
    localparam logic [REG_W-1:0] ENABLE_RESET = 16'h0000;

    // block event status layout
    localparam int unsigned      IRQ_W         = 2;
    localparam logic [IRQ_W-1:0] IRQ_IMPL_MASK = 2'h3;
    localparam logic [IRQ_W-1:0] IRQ_RESET     = 2'h0;
    localparam int unsigned      IRQ_BIT_DECODE  = 0;
    localparam int unsigned      IRQ_BIT_OVERRUN = 1;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // flag register, bit 15 first
    typedef struct packed {
        logic serial2_tx_pending;
        logic serial2_rx_pending;
        logic ext_pin2_pending;
        logic timer_five_pending;
        logic timer_four_pending;
        logic compare_ch4_pending;
        logic compare_ch3_pending;
        logic xfer_ch2_done_pending;
        logic capture_ch8_pending;
        logic capture_ch7_pending;
        logic unused_flag5;
        logic ext_pin1_pending;
        logic change_notify_pending;
        logic comparator_pending;
        logic i2c_master_pending;
        logic i2c_slave_pending;
    } ifeb_flag_t;

    // enable register, bit 15 first
    typedef struct packed {
        logic unused_enable15;
        logic xfer_ch1_done_enable;
        logic converter_done_enable;
        logic serial1_tx_enable;
        logic serial1_rx_enable;
        logic spi_event_enable;
        logic spi_error_enable;
        logic timer_three_enable;
        logic timer_two_enable;
        logic compare_ch2_enable;
        logic capture_ch2_enable;
        logic xfer_ch0_done_enable;
        logic timer_one_enable;
        logic compare_ch1_enable;
        logic capture_ch1_enable;
        logic ext_pin0_enable;
    } ifeb_enable_t;

    // write held between its channel handshakes and its commit
    typedef struct packed {
        logic [AXI_ADDR_W-1:0] addr;
        logic [AXI_DATA_W-1:0] data;
        logic [AXI_STRB_W-1:0] strb;
    } ifeb_wr_t;

endpackage : ifeb_pkg

// >>> verilog/ifeb_sticky_bank.sv
`timescale 1ns/1ns
// a bank of bits that software loads and hardware sets, set winning
module ifeb_sticky_bank
    import ifeb_pkg::*;
#(
    parameter int unsigned W          = 16,
    parameter logic [W-1:0] IMPL_MASK = '1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // software load
    input  wire logic [W-1:0] load_mask,
    input  wire logic [W-1:0] load_val,
    // hardware set
    input  wire logic [W-1:0] set_in,
    // current contents
    output logic      [W-1:0] value
);

    logic [W-1:0] next_value;   // value after this edge

    // loaded bits take the new value, a set in the same cycle wins,
    // absent bits are forced to zero
    assign next_value = ((value & ~load_mask) | (load_val & load_mask)
                         | set_in) & IMPL_MASK;

    // storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value <= RESET_VAL;
        end else begin
            value <= next_value;
        end
    end

endmodule : ifeb_sticky_bank

// >>> verilog/ifeb_top.sv
`timescale 1ns/1ns
// Operation
// - flag reads 1 once its source requested
// - flag bit 5, enable bit 15 read zero
// - flag bits 15,14,13: serial2 tx/rx, pin2
// - flag bits 12,11,10: timer5, timer4, compare4
// - flag bits 9,8: compare3, transfer channel2
// - flag bits 7,6: capture8, capture7
// - flag bits 4..0: pin1, change, comparator, i2c
// - enable bit 1 allows, 0 blocks request
// - enable bits 14,13: transfer channel1, converter
// - enable bits 12..9: serial1 tx/rx, spi
// - enable bits 8..5: timer3, timer2, compare2, capture2
// - enable bits 4..0: channel0, timer1, compare1, capture1, pin0
module ifeb_top
    import ifeb_pkg::*;
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite write address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // axi4-lite write data
    input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input  wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // axi4-lite read data
    output logic [AXI_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // peripheral event pulses for the flag register sources
    input  wire ifeb_flag_t            flag_event,
    // enables held elsewhere for the flag register sources
    input  wire ifeb_flag_t            flag_src_enable,
    // flags held elsewhere for the enable register sources
    input  wire ifeb_enable_t          enable_src_flag,
    // requests toward the core's priority logic
    output ifeb_flag_t                 flag_request,
    output ifeb_enable_t               enable_request,
    // block event interrupt
    output logic                       irq
);

    // ---------------- write channel capture ----------------
    logic                  aw_held;     // write address accepted
    logic                  w_held;      // write data accepted
    ifeb_wr_t              wr_q;        // held write payload
    logic                  wr_fire;     // both halves present
    logic [AXI_ADDR_W-1:0] wr_addr;     // word-aligned write address
    logic [REG_W-1:0]      wr_bytes;    // byte strobes as bit mask
    logic [REG_W-1:0]      wr_low;      // low half of write data
    logic                  wr_hit_flag; // write decodes
    logic                  wr_hit_en;
    logic                  wr_hit_stat;
    logic                  wr_hit_clr;
    logic                  wr_hit_ien;
    logic                  wr_mapped;   // any register hit

    // the slave takes each half once, then waits for the response
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held;

    // decode on the word address, low two bits ignored
    assign wr_addr     = {wr_q.addr[AXI_ADDR_W-1:2], 2'h0};
    assign wr_hit_flag = wr_addr == OFS_FLAG;
    assign wr_hit_en   = wr_addr == OFS_ENABLE;
    assign wr_hit_stat = wr_addr == OFS_IRQ_STATUS;
    assign wr_hit_clr  = wr_addr == OFS_IRQ_CLEAR;
    assign wr_hit_ien  = wr_addr == OFS_IRQ_ENABLE;
    assign wr_mapped   = wr_hit_flag || wr_hit_en || wr_hit_stat
                         || wr_hit_clr || wr_hit_ien;

    // only lanes 0 and 1 carry register bits
    assign wr_bytes = {{8{wr_q.strb[1]}}, {8{wr_q.strb[0]}}};
    assign wr_low   = wr_q.data[REG_W-1:0];

    // address half
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
        end
    end

    // data half
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
        end
    end

    // payload latches, no reset needed beyond a defined value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_q.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_q.data <= s_axi_wdata;
                wr_q.strb <= s_axi_wstrb;
            end
        end
    end

    // write response; status register is read-only, so it errors
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_mapped && !wr_hit_stat) ? RESP_OKAY
                                                        : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---------------- register banks ----------------
    logic [REG_W-1:0] flag_raw;      // flag register contents
    logic [REG_W-1:0] enable_raw;    // enable register contents
    logic [IRQ_W-1:0] irq_status;    // sticky block events
    logic [IRQ_W-1:0] irq_enable;    // block event mask
    logic [REG_W-1:0] flag_load;     // bits software loads
    logic [REG_W-1:0] enable_load;
    logic [IRQ_W-1:0] stat_clear;    // bits software clears
    logic [IRQ_W-1:0] ien_load;
    logic [IRQ_W-1:0] irq_set;       // block event pulses
    ifeb_flag_t       flag_q;        // field view of flags
    ifeb_enable_t     enable_q;      // field view of enables

    assign flag_load   = (wr_fire && wr_hit_flag) ? wr_bytes : '0;
    assign enable_load = (wr_fire && wr_hit_en) ? wr_bytes : '0;
    assign ien_load    = (wr_fire && wr_hit_ien && wr_q.strb[0])
                         ? IRQ_IMPL_MASK : '0;
    assign stat_clear  = (wr_fire && wr_hit_clr && wr_q.strb[0])
                         ? wr_q.data[IRQ_W-1:0] : '0;

    ifeb_sticky_bank #(
        .W         (REG_W),
        .IMPL_MASK (FLAG_IMPL_MASK),
        .RESET_VAL (FLAG_RESET)
    ) u_flag (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .load_mask (flag_load),
        .load_val  (wr_low),
        .set_in    (flag_event),
        .value     (flag_raw)
    );

    ifeb_sticky_bank #(
        .W         (REG_W),
        .IMPL_MASK (ENABLE_IMPL_MASK),
        .RESET_VAL (ENABLE_RESET)
    ) u_enable (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .load_mask (enable_load),
        .load_val  (wr_low),
        .set_in    ('0),
        .value     (enable_raw)
    );

    // block event status, cleared by writing ones to the clear word
    ifeb_sticky_bank #(
        .W         (IRQ_W),
        .IMPL_MASK (IRQ_IMPL_MASK),
        .RESET_VAL (IRQ_RESET)
    ) u_irq_status (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .load_mask (stat_clear),
        .load_val  ('0),
        .set_in    (irq_set),
        .value     (irq_status)
    );

    // block event mask
    ifeb_sticky_bank #(
        .W         (IRQ_W),
        .IMPL_MASK (IRQ_IMPL_MASK),
        .RESET_VAL (IRQ_RESET)
    ) u_irq_enable (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .load_mask (ien_load),
        .load_val  (wr_q.data[IRQ_W-1:0]),
        .set_in    ('0),
        .value     (irq_enable)
    );

    assign flag_q   = flag_raw;
    assign enable_q = enable_raw;

    // ---------------- requests ----------------
    // flag and enable
    assign flag_request   = flag_q & flag_src_enable;
    assign enable_request = enable_q & enable_src_flag;

    // ---------------- read channel ----------------
    logic [AXI_ADDR_W-1:0] rd_addr;   // word-aligned read address
    logic [REG_W-1:0]      rd_word;   // selected register
    logic                  rd_mapped; // read hits a readable word
    logic                  rd_take;   // read handshake

    assign rd_addr = {s_axi_araddr[AXI_ADDR_W-1:2], 2'h0};
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !s_axi_rvalid;

    // read mux; the clear word is write-only and reads as zero
    assign rd_word =
        (rd_addr == OFS_FLAG)       ? flag_raw :
        (rd_addr == OFS_ENABLE)     ? enable_raw :
        (rd_addr == OFS_IRQ_STATUS) ? {{(REG_W-IRQ_W){1'b0}}, irq_status} :
        (rd_addr == OFS_IRQ_ENABLE) ? {{(REG_W-IRQ_W){1'b0}}, irq_enable} :
                                      '0;
    assign rd_mapped = (rd_addr == OFS_FLAG) || (rd_addr == OFS_ENABLE)
                       || (rd_addr == OFS_IRQ_STATUS)
                       || (rd_addr == OFS_IRQ_ENABLE);

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {{(AXI_DATA_W-REG_W){1'b0}}, rd_word};
            s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- block events ----------------
    logic decode_err;   // access to no register, or a read of the write-only clear word
    logic overrun;      // event on an already pending flag

    assign decode_err = (wr_fire && !wr_mapped) || (rd_take && !rd_mapped);
    assign overrun    = |(flag_event & flag_raw);
    assign irq_set    = {overrun, decode_err};

    // level interrupt while an enabled status bit stands
    assign irq = |(irq_status & irq_enable);

    // ---------------- assertions ----------------
    property p_flag_latch;
        @(posedge aclk) disable iff (!aresetn)
        (flag_event & FLAG_IMPL_MASK) != '0 |=>
            ((flag_raw & $past(flag_event & FLAG_IMPL_MASK))
             == $past(flag_event & FLAG_IMPL_MASK));
    endproperty
    a_flag_latch: assert property (p_flag_latch)
        else $error("event did not leave its flag set");

    property p_flag_read;
        @(posedge aclk) disable iff (!aresetn)
        rd_take && rd_addr == OFS_FLAG |=>
            s_axi_rvalid && s_axi_rdata[REG_W-1:0] == $past(flag_raw);
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("flag read does not show the flag register");

    property p_reserved;
        @(posedge aclk) disable iff (!aresetn)
        !flag_q.unused_flag5 && !enable_q.unused_enable15;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("absent bit reads as one");

    property p_serial2_tx;
        @(posedge aclk) disable iff (!aresetn)
        flag_event[15] |=> flag_q.serial2_tx_pending;
    endproperty
    a_serial2_tx: assert property (p_serial2_tx)
        else $error("bit 15 event missed serial2 transmit flag");

    property p_timer_five;
        @(posedge aclk) disable iff (!aresetn)
        flag_event[12] |=> flag_raw[12] && flag_q.timer_five_pending;
    endproperty
    a_timer_five: assert property (p_timer_five)
        else $error("timer five flag not at bit 12");

    property p_enable_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_hit_en && wr_q.strb[1:0] == 2'h3 |=>
            enable_raw == ($past(wr_low) & ENABLE_IMPL_MASK);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable register did not take the write");

    property p_converter_bit;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_hit_en && wr_q.strb[1] |=>
            enable_q.converter_done_enable == $past(wr_low[13]);
    endproperty
    a_converter_bit: assert property (p_converter_bit)
        else $error("converter enable not at bit 13");

    property p_request_gate;
        @(posedge aclk) disable iff (!aresetn)
        $rose(flag_request.serial2_rx_pending) |->
            flag_raw[14] && $past(!flag_src_enable[14] || !flag_raw[14]);
    endproperty
    a_request_gate: assert property (p_request_gate)
        else $error("request rose without flag and enable");

    property p_reset_clear;
        @(posedge aclk)
        !aresetn |=> flag_raw == FLAG_RESET && enable_raw == ENABLE_RESET;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("registers not clear after reset");

    property p_resp_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_resp_hold: assert property (p_resp_hold)
        else $error("write response dropped before bready");

endmodule : ifeb_top
